// ---- design/lcs_csr_bank.sv ----
// How it works
// - Every maintenance access and every window-hit access whose offset lies in 0x40 to 0xFC is served by this bank's configuration port.
// - The addressing-capability control register reads 0x00000001 and ignores writes.
// - The upper window base register reads all zeros and ignores writes.
// - The lower window base resets to a build value and is written by maintenance or window-hit writes.
// - A rewritten window base is used at once for the following address comparisons.
// - Only bits 30:21 of the lower base are writable and compared; bits 31 and 20:0 read zero.
// - The window base is compared with address bits 34:25 and a match sends the access to this bank.
// - The window spans all address bits below the compared field, so offsets come from the low bits.
// - The node identifier holds an 8-bit id in 23:16 and, with large systems, a 16-bit id in 15:0.
// - The top byte of the node identifier reads zero and writes to it are dropped.
// - The host identifier resets to 0x0000FFFF and takes one locking write after reset.
// - While locked only a write equal to the stored id is taken, and it reopens the field to all ones.
// - The unlock compare needs both low byte lanes written in the same access.
// - Writing all ones to the host identifier leaves it open.
// - The component label resets to zero and is read-write through either access path.
`default_nettype none
module lcs_csr_bank #(
    parameter logic [lcs_pkg::BASE_W-1:0]     BASE_RESET     = '0,
    parameter logic [lcs_pkg::SMALL_ID_W-1:0] SMALL_ID_RESET = '0,
    parameter logic [lcs_pkg::WIDE_ID_W-1:0]  WIDE_ID_RESET  = '0,
    parameter bit                             LARGE_SYSTEM   = 1'b1
) (
    // Clock and reset
    input  wire logic                            clk,
    input  wire logic                            rst_n,
    // Maintenance access
    input  wire logic                            mnt_valid,
    output logic                                 mnt_ready,
    input  wire logic                            mnt_write,
    input  wire logic [lcs_pkg::OFF_W-1:0]       mnt_offset,
    input  wire logic [lcs_pkg::DATA_W-1:0]      mnt_wdata,
    input  wire logic [lcs_pkg::BE_W-1:0]        mnt_be,
    // Normal read or write to be matched against the window
    input  wire logic                            nrm_valid,
    output logic                                 nrm_ready,
    input  wire logic                            nrm_write,
    input  wire logic [lcs_pkg::ADDR_W-1:0]      nrm_addr,
    input  wire logic [lcs_pkg::DATA_W-1:0]      nrm_wdata,
    input  wire logic [lcs_pkg::BE_W-1:0]        nrm_be,
    output logic                                 nrm_hit,
    // Response
    output logic                                 rsp_valid,
    output logic      [lcs_pkg::DATA_W-1:0]      rsp_rdata,
    output logic                                 rsp_from_normal,
    output logic                                 rsp_unmapped,
    // Register contents for the endpoint
    output logic      [lcs_pkg::BASE_W-1:0]      config_window_base_field,
    output logic      [lcs_pkg::SMALL_ID_W-1:0]  small_node_identifier,
    output logic      [lcs_pkg::WIDE_ID_W-1:0]   wide_node_identifier,
    output logic      [lcs_pkg::HOST_ID_W-1:0]   owner_host_identifier,
    output logic                                 host_id_locked
);
    lcs_wr_if wr ();

    logic                             take_mnt;
    logic                             take_nrm;
    logic                             take;
    logic                             acc_write;
    logic [lcs_pkg::OFF_W-1:0]        acc_off;
    logic [lcs_pkg::DATA_W-1:0]       acc_wdata;
    logic [lcs_pkg::BE_W-1:0]         acc_be;
    logic                             in_range;
    logic [7:0]                       reg_off;
    logic                             sel_cap;
    logic                             sel_base_hi;
    logic                             sel_base_lo;
    logic                             sel_node;
    logic                             sel_lock;
    logic                             sel_label;
    logic                             wr_node;
    logic                             wr_label;
    logic [lcs_pkg::SMALL_ID_W-1:0]   small_id_ff;
    logic [lcs_pkg::WIDE_ID_W-1:0]    wide_id_ff;
    logic [lcs_pkg::DATA_W-1:0]       label_ff;
    logic [lcs_pkg::DATA_W-1:0]       node_word;
    logic [lcs_pkg::DATA_W-1:0]       node_merged;
    logic [lcs_pkg::DATA_W-1:0]       base_lo_word;
    logic [lcs_pkg::DATA_W-1:0]       lock_word;
    logic [lcs_pkg::DATA_W-1:0]       read_word;
    logic [lcs_pkg::SMALL_ID_W-1:0]   nxt_small_id;
    logic [lcs_pkg::WIDE_ID_W-1:0]    nxt_wide_id;
    logic [lcs_pkg::DATA_W-1:0]       nxt_label;
    logic                             rsp_valid_ff;
    logic [lcs_pkg::DATA_W-1:0]       rsp_rdata_ff;
    logic                             rsp_from_normal_ff;
    logic                             rsp_unmapped_ff;
    logic [lcs_pkg::BASE_W-1:0]       base_field;
    logic [lcs_pkg::HOST_ID_W-1:0]    host_id;
    logic                             locked;

    // Maintenance accesses win over normal window hits
    assign take_mnt  = mnt_valid;
    assign take_nrm  = nrm_valid && nrm_hit && !mnt_valid;
    assign take      = take_mnt || take_nrm;
    assign mnt_ready = 1'b1;
    assign nrm_ready = !mnt_valid;

    assign acc_write = take_mnt ? mnt_write  : nrm_write;
    assign acc_off   = take_mnt ? mnt_offset : nrm_addr[lcs_pkg::OFF_W-1:0];
    assign acc_wdata = take_mnt ? mnt_wdata  : nrm_wdata;
    assign acc_be    = take_mnt ? mnt_be     : nrm_be;

    // Offset decode over the command and status range
    assign in_range    = (acc_off[lcs_pkg::OFF_W-1:8] == '0)
                         && (acc_off[7:6] != lcs_pkg::RANGE_LOW_QUAD);
    assign reg_off     = {acc_off[7:2], 2'b00};
    assign sel_cap     = in_range && (reg_off == lcs_pkg::OFF_ADDR_CAP);
    assign sel_base_hi = in_range && (reg_off == lcs_pkg::OFF_BASE_HIGH);
    assign sel_base_lo = in_range && (reg_off == lcs_pkg::OFF_BASE_LOW);
    assign sel_node    = in_range && (reg_off == lcs_pkg::OFF_NODE_ID);
    assign sel_lock    = in_range && (reg_off == lcs_pkg::OFF_HOST_LOCK);
    assign sel_label   = in_range && (reg_off == lcs_pkg::OFF_LABEL);

    // Write strobe shared with the base and lock registers
    assign wr.wr_en = take && acc_write && in_range;
    assign wr.off   = reg_off;
    assign wr.wdata = acc_wdata;
    assign wr.be    = acc_be;

    lcs_win_base #(
        .BASE_RESET (BASE_RESET)
    ) u_win_base (
        .clk        (clk),
        .rst_n      (rst_n),
        .wr         (wr.sink),
        .cmp_addr   (nrm_addr),
        .base_field (base_field),
        .hit        (nrm_hit)
    );

    lcs_host_lock u_host_lock (
        .clk     (clk),
        .rst_n   (rst_n),
        .wr      (wr.sink),
        .host_id (host_id),
        .locked  (locked)
    );

    // Node identifier; without large systems the wide field reads zero and ignores writes, but keeps its reset value at the port
    assign wr_node      = wr.wr_en && sel_node;
    assign node_word    = {8'h00, small_id_ff, (LARGE_SYSTEM ? wide_id_ff : 16'h0000)};
    assign node_merged  = lcs_pkg::merge_bytes(node_word, acc_wdata, acc_be);
    assign nxt_small_id = wr_node ? node_merged[23:16] : small_id_ff;
    assign nxt_wide_id  = (wr_node && LARGE_SYSTEM) ? node_merged[15:0] : wide_id_ff;

    // Component label, full word read-write
    assign wr_label  = wr.wr_en && sel_label;
    assign nxt_label = wr_label ? lcs_pkg::merge_bytes(label_ff, acc_wdata, acc_be) : label_ff;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            small_id_ff <= SMALL_ID_RESET;
            wide_id_ff  <= WIDE_ID_RESET;
            label_ff    <= lcs_pkg::LABEL_RESET;
        end else begin
            small_id_ff <= nxt_small_id;
            wide_id_ff  <= nxt_wide_id;
            label_ff    <= nxt_label;
        end
    end

    // Read views of each register
    assign base_lo_word = {1'b0, base_field, 21'h00_0000};
    assign lock_word    = {16'h0000, host_id};

    always_comb begin
        read_word = '0;
        if (sel_cap) begin
            read_word = lcs_pkg::ADDR_CAP_VALUE;
        end else if (sel_base_hi) begin
            read_word = lcs_pkg::BASE_HIGH_VAL;
        end else if (sel_base_lo) begin
            read_word = base_lo_word;
        end else if (sel_node) begin
            read_word = node_word;
        end else if (sel_lock) begin
            read_word = lock_word;
        end else if (sel_label) begin
            read_word = label_ff;
        end
    end

    // One response per taken access, one cycle later; writes answer zero
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rsp_valid_ff       <= 1'b0;
            rsp_rdata_ff       <= '0;
            rsp_from_normal_ff <= 1'b0;
            rsp_unmapped_ff    <= 1'b0;
        end else begin
            rsp_valid_ff       <= take;
            rsp_rdata_ff       <= (take && !acc_write) ? read_word : '0;
            rsp_from_normal_ff <= take_nrm;
            rsp_unmapped_ff    <= take && !in_range;
        end
    end

    assign rsp_valid                = rsp_valid_ff;
    assign rsp_rdata                = rsp_rdata_ff;
    assign rsp_from_normal          = rsp_from_normal_ff;
    assign rsp_unmapped             = rsp_unmapped_ff;
    assign config_window_base_field = base_field;
    assign small_node_identifier    = small_id_ff;
    assign wide_node_identifier     = wide_id_ff;
    assign owner_host_identifier    = host_id;
    assign host_id_locked           = locked;
endmodule : lcs_csr_bank
`default_nettype wire

// ---- design/lcs_pkg.sv ----
`default_nettype none
package lcs_pkg;
    // Access widths
    localparam int unsigned ADDR_W         = 35;
    localparam int unsigned OFF_W          = 24;
    localparam int unsigned DATA_W         = 32;
    localparam int unsigned BE_W           = 4;

    // Register byte offsets within configuration space
    localparam logic [7:0]  OFF_ADDR_CAP   = 8'h4C;
    localparam logic [7:0]  OFF_BASE_HIGH  = 8'h58;
    localparam logic [7:0]  OFF_BASE_LOW   = 8'h5C;
    localparam logic [7:0]  OFF_NODE_ID    = 8'h60;
    localparam logic [7:0]  OFF_HOST_LOCK  = 8'h68;
    localparam logic [7:0]  OFF_LABEL      = 8'h6C;

    // Command and status range: 0x40 to 0xFC
    localparam logic [1:0]  RANGE_LOW_QUAD = 2'h0;

    // Fixed read values and reset values
    localparam logic [31:0] ADDR_CAP_VALUE = 32'h0000_0001;
    localparam logic [31:0] BASE_HIGH_VAL  = 32'h0000_0000;
    localparam logic [15:0] HOST_ID_OPEN   = 16'hFFFF;
    localparam logic [31:0] LABEL_RESET    = 32'h0000_0000;

    // Window base field layout and compared address bits
    localparam int unsigned BASE_LSB       = 21;
    localparam int unsigned BASE_MSB       = 30;
    localparam int unsigned BASE_W         = 10;
    localparam int unsigned CMP_LSB        = 25;
    localparam int unsigned CMP_MSB        = 34;

    // Node identifier field layout
    localparam int unsigned SMALL_ID_LSB   = 16;
    localparam int unsigned SMALL_ID_W     = 8;
    localparam int unsigned WIDE_ID_W      = 16;
    localparam int unsigned HOST_ID_W      = 16;

    // Byte-lane merge of a write into a stored word
    function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                                input logic [31:0] new_v,
                                                input logic [3:0]  be);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction : merge_bytes
endpackage : lcs_pkg
`default_nettype wire

// ---- design/lcs_wr_if.sv ----
`default_nettype none
interface lcs_wr_if;
    logic        wr_en;
    logic [7:0]  off;
    logic [31:0] wdata;
    logic [3:0]  be;

    modport src  (output wr_en, output off, output wdata, output be);
    modport sink (input wr_en, input off, input wdata, input be);
endinterface : lcs_wr_if
`default_nettype wire

// ---- design/lcs_win_base.sv ----
`default_nettype none
module lcs_win_base #(
    parameter logic [lcs_pkg::BASE_W-1:0] BASE_RESET = '0
) (
    // Clock and reset
    input  wire logic                        clk,
    input  wire logic                        rst_n,
    // Register writes
    lcs_wr_if.sink                           wr,
    // Address comparison
    input  wire logic [lcs_pkg::ADDR_W-1:0]  cmp_addr,
    output logic      [lcs_pkg::BASE_W-1:0]  base_field,
    output logic                             hit
);
    logic [lcs_pkg::BASE_W-1:0] base_ff;
    logic [lcs_pkg::BASE_W-1:0] nxt_base;
    logic                       sel_wr;
    logic [31:0]                merged;

    assign sel_wr   = wr.wr_en && (wr.off == lcs_pkg::OFF_BASE_LOW);
    assign merged   = lcs_pkg::merge_bytes({1'b0, base_ff, 21'h00_0000}, wr.wdata, wr.be);
    // Only the ten window bits are kept; the rest always read zero
    assign nxt_base = sel_wr ? merged[lcs_pkg::BASE_MSB:lcs_pkg::BASE_LSB] : base_ff;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            base_ff <= BASE_RESET;
        end else begin
            base_ff <= nxt_base;
        end
    end

    // Low address bits all fall inside the window
    assign hit        = (cmp_addr[lcs_pkg::CMP_MSB:lcs_pkg::CMP_LSB] == base_ff);
    assign base_field = base_ff;
endmodule : lcs_win_base
`default_nettype wire

// ---- design/lcs_host_lock.sv ----
`default_nettype none
module lcs_host_lock (
    // Clock and reset
    input  wire logic                           clk,
    input  wire logic                           rst_n,
    // Register writes
    lcs_wr_if.sink                              wr,
    // Lock state
    output logic      [lcs_pkg::HOST_ID_W-1:0]  host_id,
    output logic                                locked
);
    logic [lcs_pkg::HOST_ID_W-1:0] id_ff;
    logic [lcs_pkg::HOST_ID_W-1:0] nxt_id;
    logic                          sel_wr;
    logic                          full_word;
    logic                          match;
    logic [31:0]                   merged;

    assign sel_wr    = wr.wr_en && (wr.off == lcs_pkg::OFF_HOST_LOCK);
    assign merged    = lcs_pkg::merge_bytes({16'h0000, id_ff}, wr.wdata, wr.be);
    assign full_word = (wr.be[1:0] == 2'b11);
    assign match     = full_word && (wr.wdata[15:0] == id_ff);
    // Open while holding all ones; a write of all ones keeps it open
    assign locked    = (id_ff != lcs_pkg::HOST_ID_OPEN);

    always_comb begin
        nxt_id = id_ff;
        if (sel_wr && !locked) begin
            nxt_id = merged[15:0];
        end else if (sel_wr && match) begin
            nxt_id = lcs_pkg::HOST_ID_OPEN;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            id_ff <= lcs_pkg::HOST_ID_OPEN;
        end else begin
            id_ff <= nxt_id;
        end
    end

    assign host_id = id_ff;
endmodule : lcs_host_lock
`default_nettype wire

// ---- sim/lcs_csr_bank_sva.sv ----
`default_nettype none
module lcs_csr_bank_sva (
    // Clock and reset
    input wire logic         clk,
    input wire logic         rst_n,
    // Requests
    input wire logic         mnt_valid,
    input wire logic         mnt_ready,
    input wire logic         mnt_write,
    input wire logic [23:0]  mnt_offset,
    input wire logic [31:0]  mnt_wdata,
    input wire logic [3:0]   mnt_be,
    input wire logic         nrm_valid,
    input wire logic         nrm_ready,
    input wire logic [34:0]  nrm_addr,
    input wire logic         nrm_hit,
    // Responses and state
    input wire logic         rsp_valid,
    input wire logic [31:0]  rsp_rdata,
    input wire logic         rsp_from_normal,
    input wire logic [9:0]   config_window_base_field,
    input wire logic [15:0]  owner_host_identifier,
    input wire logic         host_id_locked
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire logic rd_cap  = mnt_valid && !mnt_write && mnt_offset[23:2] == 22'h13;
    wire logic rd_high = mnt_valid && !mnt_write && mnt_offset[23:2] == 22'h16;
    wire logic rd_low  = mnt_valid && !mnt_write && mnt_offset[23:2] == 22'h17;
    wire logic wr_host = mnt_valid && mnt_write && mnt_offset[23:2] == 22'h1A;
    chk_ready_levels: assert property (mnt_ready && nrm_ready == !mnt_valid)
        else $error("ready levels wrong");
    chk_mnt_answer: assert property (mnt_valid |=> rsp_valid && !rsp_from_normal)
        else $error("maintenance access not answered");
    chk_nrm_answer: assert property (!mnt_valid && nrm_valid && nrm_hit |=> rsp_valid && rsp_from_normal)
        else $error("window access not answered");
    chk_idle_quiet: assert property (!mnt_valid && !(nrm_valid && nrm_hit) |=> !rsp_valid)
        else $error("response without taken access");
    chk_cap_value: assert property (rd_cap |=> rsp_rdata == 32'h0000_0001)
        else $error("capability read wrong");
    chk_high_zero: assert property (rd_high |=> rsp_rdata == 32'h0000_0000)
        else $error("upper base read not zero");
    chk_low_layout: assert property (rd_low |=> rsp_rdata == {1'b0, $past(config_window_base_field), 21'h0})
        else $error("lower base read wrong");
    chk_hit_compare: assert property (nrm_hit == (nrm_addr[34:25] == config_window_base_field))
        else $error("window compare wrong");
    chk_lock_flag: assert property (host_id_locked == (owner_host_identifier != 16'hFFFF))
        else $error("lock flag wrong");
    chk_lock_hold: assert property (host_id_locked && mnt_valid && (mnt_be[1:0] != 2'b11 ||
        mnt_wdata[15:0] != owner_host_identifier) |=> $stable(owner_host_identifier))
        else $error("locked host id changed");
    chk_unlock_open: assert property (host_id_locked && wr_host && mnt_be[1:0] == 2'b11 &&
        mnt_wdata[15:0] == owner_host_identifier |=> owner_host_identifier == 16'hFFFF)
        else $error("matching write did not unlock");
endmodule : lcs_csr_bank_sva
bind lcs_csr_bank lcs_csr_bank_sva i_lcs_csr_bank_sva (
    .clk(clk), .rst_n(rst_n), .mnt_valid(mnt_valid), .mnt_ready(mnt_ready), .mnt_write(mnt_write),
    .mnt_offset(mnt_offset), .mnt_wdata(mnt_wdata), .mnt_be(mnt_be), .nrm_valid(nrm_valid),
    .nrm_ready(nrm_ready), .nrm_addr(nrm_addr), .nrm_hit(nrm_hit), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .rsp_from_normal(rsp_from_normal), .config_window_base_field(config_window_base_field),
    .owner_host_identifier(owner_host_identifier), .host_id_locked(host_id_locked));
`default_nettype wire

// ---- sim/lcs_fabric_model.sv ----
`default_nettype none
module lcs_fabric_model (
    // Clock and readiness
    input  wire logic         clk,
    input  wire logic         mnt_ready,
    input  wire logic         nrm_ready,
    // Maintenance request
    output logic              mnt_valid,
    output logic              mnt_write,
    output logic [23:0]       mnt_offset,
    output logic [31:0]       mnt_wdata,
    output logic [3:0]        mnt_be,
    // Normal request
    output logic              nrm_valid,
    output logic              nrm_write,
    output logic [34:0]       nrm_addr,
    output logic [31:0]       nrm_wdata,
    output logic [3:0]        nrm_be
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {mnt_valid, mnt_write, mnt_offset, mnt_wdata, mnt_be} = '0;
        {nrm_valid, nrm_write, nrm_addr, nrm_wdata, nrm_be} = '0;
    end
    // One word per request with its byte enables, held until the port shows ready or eight cycles pass
    task automatic send(input logic nrm, input logic wr, input logic [34:0] addr,
                        input logic [31:0] wd, input logic [3:0] be);
        @(posedge clk);
        if (nrm) begin
            {nrm_valid, nrm_write, nrm_addr, nrm_wdata, nrm_be} <= {1'b1, wr, addr, wd, be};
        end else begin
            {mnt_valid, mnt_write, mnt_offset, mnt_wdata, mnt_be} <= {1'b1, wr, addr[23:0], wd, be};
        end
        for (int n = 0; n < 8; n++) begin
            @(posedge clk);
            if (nrm ? nrm_ready : mnt_ready) break;
        end
        // Released lines flip so stale values never look valid
        {mnt_valid, nrm_valid} <= 2'b00;
        {mnt_offset, mnt_wdata, nrm_addr, nrm_wdata} <= ~{mnt_offset, mnt_wdata, nrm_addr, nrm_wdata};
    endtask : send
endmodule : lcs_fabric_model
`default_nettype wire

// ---- sim/testbench.sv ----
`default_nettype none
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin miscompares++; \
    $display("BAD t=%0t got=%h exp=%h", $time, got, exp); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic nrm; logic wr; logic [34:0] addr; logic [31:0] wd; logic [3:0] be; logic [31:0] exp;
    } lcs_row_t;
    localparam logic [9:0]  BASE_RST  = 10'h155;
    localparam logic [7:0]  SMALL_RST = 8'h5A;
    localparam logic [15:0] WIDE_RST  = 16'h1234;
    lcs_row_t rows [26] = '{
        '{1'b0, 1'b1, 35'h4C, 32'hFFFF_FFFF, 4'hF, 32'h0},
        '{1'b0, 1'b0, 35'h4C, 32'h0, 4'hF, 32'h0000_0001},
        '{1'b0, 1'b1, 35'h58, 32'hFFFF_FFFF, 4'hF, 32'h0},
        '{1'b0, 1'b0, 35'h58, 32'h0, 4'hF, 32'h0},
        '{1'b0, 1'b0, 35'h5C, 32'h0, 4'hF, 32'h2AA0_0000},
        '{1'b0, 1'b0, 35'h60, 32'h0, 4'hF, 32'h005A_1234},
        '{1'b0, 1'b1, 35'h60, 32'hFFFF_FFFF, 4'hF, 32'h0},
        '{1'b0, 1'b0, 35'h60, 32'h0, 4'hF, 32'h00FF_FFFF},
        '{1'b0, 1'b1, 35'h64, 32'hFFFF_FFFF, 4'hF, 32'h0},
        '{1'b0, 1'b0, 35'h64, 32'h0, 4'hF, 32'h0},
        '{1'b0, 1'b1, 35'h5C, 32'hFFFF_FFFF, 4'hF, 32'h0},
        '{1'b0, 1'b0, 35'h5C, 32'h0, 4'hF, 32'h7FE0_0000},
        '{1'b1, 1'b1, {10'h3FF, 25'h6C}, 32'h1234_5678, 4'hF, 32'h0},
        '{1'b0, 1'b0, 35'h6C, 32'h0, 4'hF, 32'h1234_5678},
        '{1'b1, 1'b0, {10'h3FF, 25'h100_006C}, 32'h0, 4'hF, 32'h1234_5678},
        '{1'b1, 1'b1, {10'h3FF, 25'h5C}, 32'h0020_0000, 4'hF, 32'h0},
        '{1'b1, 1'b0, {10'h001, 25'h6C}, 32'h0, 4'hF, 32'h1234_5678},
        '{1'b0, 1'b1, 35'h68, 32'h0000_FFFF, 4'hF, 32'h0},
        '{1'b0, 1'b0, 35'h68, 32'h0, 4'hF, 32'h0000_FFFF},
        '{1'b0, 1'b1, 35'h68, 32'hABCD_0042, 4'hF, 32'h0},
        '{1'b0, 1'b1, 35'h68, 32'h0000_0099, 4'hF, 32'h0},
        '{1'b0, 1'b0, 35'h68, 32'h0, 4'hF, 32'h0000_0042},
        '{1'b0, 1'b1, 35'h68, 32'h0000_0042, 4'h1, 32'h0},
        '{1'b0, 1'b0, 35'h68, 32'h0, 4'hF, 32'h0000_0042},
        '{1'b0, 1'b1, 35'h68, 32'h0000_0042, 4'hF, 32'h0},
        '{1'b0, 1'b0, 35'h68, 32'h0, 4'hF, 32'h0000_FFFF}};
    logic clk, rst_n, mnt_valid, mnt_ready, mnt_write, nrm_valid, nrm_ready, nrm_write, nrm_hit;
    logic rsp_valid, rsp_from_normal, rsp_unmapped, host_id_locked;
    logic [23:0] mnt_offset;
    logic [34:0] nrm_addr;
    logic [31:0] mnt_wdata, nrm_wdata, rsp_rdata;
    logic [3:0]  mnt_be, nrm_be;
    logic [9:0]  config_window_base_field;
    logic [7:0]  small_node_identifier;
    logic [15:0] wide_node_identifier, owner_host_identifier;
    int          miscompares, check_count, cycles;
    lcs_csr_bank #(.BASE_RESET(BASE_RST), .SMALL_ID_RESET(SMALL_RST), .WIDE_ID_RESET(WIDE_RST)) i_lcs_csr_bank (
        .clk, .rst_n, .mnt_valid, .mnt_ready, .mnt_write, .mnt_offset, .mnt_wdata, .mnt_be, .nrm_valid,
        .nrm_ready, .nrm_write, .nrm_addr, .nrm_wdata, .nrm_be, .nrm_hit, .rsp_valid, .rsp_rdata,
        .rsp_from_normal, .rsp_unmapped, .config_window_base_field, .small_node_identifier,
        .wide_node_identifier, .owner_host_identifier, .host_id_locked);
    lcs_fabric_model i_lcs_fabric_model (.clk, .mnt_ready, .nrm_ready, .mnt_valid, .mnt_write, .mnt_offset,
        .mnt_wdata, .mnt_be, .nrm_valid, .nrm_write, .nrm_addr, .nrm_wdata, .nrm_be);
    // Same traffic into a bank built without large-system support
    logic [31:0] rdata_small;
    lcs_csr_bank #(.BASE_RESET(BASE_RST), .SMALL_ID_RESET(SMALL_RST), .WIDE_ID_RESET(WIDE_RST),
        .LARGE_SYSTEM(1'b0)) i_lcs_csr_bank_small (
        .clk, .rst_n, .mnt_valid, .mnt_ready(), .mnt_write, .mnt_offset, .mnt_wdata, .mnt_be, .nrm_valid,
        .nrm_ready(), .nrm_write, .nrm_addr, .nrm_wdata, .nrm_be, .nrm_hit(), .rsp_valid(),
        .rsp_rdata(rdata_small), .rsp_from_normal(), .rsp_unmapped(), .config_window_base_field(),
        .small_node_identifier(), .wide_node_identifier(), .owner_host_identifier(), .host_id_locked());
    task automatic tally_and_finish();
        if (miscompares == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 1000) begin
            miscompares++;
            tally_and_finish();
        end
    end
    initial begin
        rst_n = 1'b0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 26; i++) begin
            i_lcs_fabric_model.send(rows[i].nrm, rows[i].wr, rows[i].addr, rows[i].wd, rows[i].be);
            #1;
            `CHK({rsp_valid, rsp_from_normal, rsp_rdata}, {1'b1, rows[i].nrm, rows[i].exp})
            if (!rows[i].wr && rows[i].addr == 35'h60) begin
                `CHK(rdata_small, rows[i].exp & 32'hFFFF_0000)
            end
        end
        // Old window base no longer matches
        i_lcs_fabric_model.send(1'b1, 1'b0, {10'h3FF, 25'h6C}, 32'h0, 4'hF);
        #1;
        `CHK(rsp_valid, 1'b0)
        // Offset past the command range
        i_lcs_fabric_model.send(1'b0, 1'b0, 35'h100, 32'h0, 4'hF);
        #1;
        `CHK({rsp_unmapped, rsp_rdata}, {1'b1, 32'h0})
        // Lock, then reset in mid-run
        i_lcs_fabric_model.send(1'b0, 1'b1, 35'h68, 32'h0000_0077, 4'hF);
        #1;
        `CHK({owner_host_identifier, host_id_locked}, {16'h0077, 1'b1})
        @(posedge clk);
        rst_n <= 1'b0;
        @(posedge clk);
        #1;
        `CHK({owner_host_identifier, host_id_locked, rsp_valid}, {16'hFFFF, 1'b0, 1'b0})
        `CHK(config_window_base_field, BASE_RST)
        `CHK({small_node_identifier, wide_node_identifier}, {SMALL_RST, WIDE_RST})
        @(posedge clk);
        rst_n <= 1'b1;
        i_lcs_fabric_model.send(1'b0, 1'b0, 35'h6C, 32'h0, 4'hF);
        #1;
        `CHK({rsp_valid, rsp_rdata}, {1'b1, 32'h0})
        tally_and_finish();
    end
endmodule : testbench
`default_nettype wire
